// ### command_pulse_decoder_gear.sv
// Command pulse input stage: path select, format decode, electronic gear.
// Assumes pulse pins are already synchronous to clk and that power_up
// pulses once when control power comes up.
`timescale 1ns/1ps

// Notes on behaviour
// [RL1] Path 0 takes optocoupler inputs, 1 takes dedicated differential inputs.
// [RL2] Inversion swaps which decoded pattern counts positive and negative.
// [RL3] Format 0 or 2 quadrature, 1 separate trains, 3 pulse plus direction.
// [RL4] Quadrature, no inversion: sign leading pulse by 90 degrees is positive.
// [RL5] Quadrature, inverted: sign lagging pulse by 90 degrees is positive.
// [RL6] Separate trains: one line up, other down; otherwise sign sets direction.
// [RL7] Host keeps rates within 4 Mpps, 500 kpps, 200 kpps per path.
// [RL8] Nonzero pulses per rev: that many pulses give one revolution.
// [RL9] Zero pulses per rev: use gear numerator over denominator instead.
// [RL10] Gear numerator 0 to 2^30, default 0, multiplies counted pulses.
// [RL11] Gear denominator 1 to 2^30, default 10000, divides the product.
// [RL12] Path, direction, format, pulses per rev load only at power-up.
// [RL13] Pulses per rev and numerator both zero: denominator is pulses per rev.
// [RL14] Quadrature counts every edge of both phases, else one per pulse.
// [RL15] Gear remainder carries over so scaled output never drifts.
module command_pulse_decoder_gear
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Optocoupler path
   input wire logic opto_pulse_pos,
   input wire logic opto_pulse_neg,
   input wire logic opto_sign_pos,
   input wire logic opto_sign_neg,
   // Dedicated differential path
   input wire logic diff_pulse_pos,
   input wire logic diff_pulse_neg,
   input wire logic diff_sign_pos,
   input wire logic diff_sign_neg,
   // Settings
   input wire logic power_up,
   input wire logic input_path_select,
   input wire logic direction_invert,
   input wire logic [1:0] pulse_format_select,
   input wire logic [cpd_pkg::PPR_W-1:0] pulses_per_rev,
   input wire logic [cpd_pkg::GEAR_W-1:0] gear_numerator,
   input wire logic [cpd_pkg::GEAR_W-1:0] gear_denominator,
   // Command outputs
   output logic cmd_step_pos,
   output logic cmd_step_neg,
   output logic signed [cpd_pkg::CNT_W-1:0] cmd_count,
   output logic signed [cpd_pkg::POS_W-1:0] position_cmd
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic path;
      logic inv;
      logic [1:0] fmt;
      logic [cpd_pkg::PPR_W-1:0] ppr;
      logic pulse_lvl;
      logic sign_lvl;
      logic step_pos;
      logic step_neg;
      logic signed [cpd_pkg::CNT_W-1:0] count;
      logic signed [cpd_pkg::POS_W-1:0] pos_cmd;
   } dec_reg_t;

   localparam dec_reg_t DEC_RESET = '{
      path: cpd_pkg::PATH_DEFAULT,
      inv: cpd_pkg::INVERT_DEFAULT,
      fmt: cpd_pkg::FMT_DEFAULT,
      ppr: cpd_pkg::PPR_DEFAULT,
      pulse_lvl: 1'b0,
      sign_lvl: 1'b0,
      step_pos: 1'b0,
      step_neg: 1'b0,
      count: '0,
      pos_cmd: '0
   };

   dec_reg_t r_reg;
   dec_reg_t r_next;
   logic pulse_new;
   logic sign_new;
   logic pulse_rise;
   logic sign_rise;
   logic ev;
   logic up;

   gear_link_if lnk ();

   // A differential pair with both legs equal is no valid level; hold
   function automatic logic line_level(input logic p, input logic n,
      input logic prev);
      line_level = (p != n) ? p : prev;
   endfunction

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   always_comb
   begin
      r_next = r_reg;
      // [RL1] choose input path
      if (r_reg.path)
      begin
         pulse_new = line_level(diff_pulse_pos, diff_pulse_neg,
            r_reg.pulse_lvl);
         sign_new = line_level(diff_sign_pos, diff_sign_neg, r_reg.sign_lvl);
      end
      else
      begin
         pulse_new = line_level(opto_pulse_pos, opto_pulse_neg,
            r_reg.pulse_lvl);
         sign_new = line_level(opto_sign_pos, opto_sign_neg, r_reg.sign_lvl);
      end
      pulse_rise = pulse_new & ~r_reg.pulse_lvl;
      sign_rise = sign_new & ~r_reg.sign_lvl;
      ev = 1'b0;
      up = 1'b0;
      // [RL3] format decode
      case (r_reg.fmt)
         cpd_pkg::FMT_QUAD0, cpd_pkg::FMT_QUAD2:
         begin
            // [RL14] every edge, double steps ignored
            if ((pulse_new != r_reg.pulse_lvl) != (sign_new != r_reg.sign_lvl))
            begin
               ev = 1'b1;
               // [RL4] sign leading counts up
               up = r_reg.pulse_lvl ^ sign_new;
            end
         end
         cpd_pkg::FMT_SEPARATE:
         begin
            // [RL6] coincident pulses cancel
            ev = pulse_rise ^ sign_rise;
            up = pulse_rise;
         end
         cpd_pkg::FMT_PULSE_DIR:
         begin
            // [RL6] sign level sets direction
            ev = pulse_rise;
            up = sign_new;
         end
         default:
         begin
            ev = 1'b0;
            up = 1'b0;
         end
      endcase
      // [RL2] [RL5] inversion swaps direction
      up = up ^ r_reg.inv;
      r_next.pulse_lvl = pulse_new;
      r_next.sign_lvl = sign_new;
      r_next.step_pos = ev & up;
      r_next.step_neg = ev & ~up;
      if (ev)
         r_next.count = up ? r_reg.count + 32'sh1 : r_reg.count - 32'sh1;
      // [RL12] starred settings load at power-up only
      if (power_up)
      begin
         r_next.path = input_path_select;
         r_next.inv = direction_invert;
         r_next.fmt = pulse_format_select;
         r_next.ppr = pulses_per_rev;
      end
      if (lnk.q_valid)
         r_next.pos_cmd = r_reg.pos_cmd + lnk.q;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         r_reg <= DEC_RESET;
      else
         r_reg <= r_next;
   end

   // -----------------------------------------------------------------
   // Gear ratio and scaler
   // -----------------------------------------------------------------
   // Numerator and denominator act live; only pulses per rev is latched
   always_comb
   begin
      lnk.ev_valid = r_reg.step_pos | r_reg.step_neg;
      lnk.ev_up = r_reg.step_pos;
      // [RL8] pulses per rev wins
      if (r_reg.ppr != cpd_pkg::PPR_OFF)
      begin
         lnk.num = cpd_pkg::ENC_RES;
         lnk.den = (cpd_pkg::GEAR_W)'(r_reg.ppr);
      end
      // [RL13] denominator as pulses per rev
      else if (gear_numerator == cpd_pkg::GEAR_ZERO)
      begin
         lnk.num = cpd_pkg::ENC_RES;
         lnk.den = gear_denominator;
      end
      // [RL9] numerator over denominator
      else
      begin
         lnk.num = gear_numerator;
         lnk.den = gear_denominator;
      end
   end

   gear_scaler gear
   (
      .clk(clk),
      .reset(reset),
      .lnk(lnk.gear)
   );

   assign cmd_step_pos = r_reg.step_pos;
   assign cmd_step_neg = r_reg.step_neg;
   assign cmd_count = r_reg.count;
   assign position_cmd = r_reg.pos_cmd;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_settings_hold;
      @(posedge clk) disable iff (reset)
      !power_up |=> $stable({r_reg.path, r_reg.inv, r_reg.fmt, r_reg.ppr});
   endproperty
   a_settings_hold: assert property (p_settings_hold) // [RL12]
      else $error("latched setting changed without power-up");

   property p_path_load;
      @(posedge clk) disable iff (reset)
      power_up |=> r_reg.path == $past(input_path_select)
         && r_reg.fmt == $past(pulse_format_select);
   endproperty
   a_path_load: assert property (p_path_load) // [RL1]
      else $error("path or format not loaded at power-up");

   property p_quad_lead;
      @(posedge clk) disable iff (reset)
      (r_reg.fmt[0] == 1'b0 && !r_reg.inv && !r_reg.pulse_lvl && !pulse_new
         && !r_reg.sign_lvl && sign_new)
         |=> cmd_count == $past(cmd_count) + 32'sh1 && lnk.ev_valid
         && lnk.ev_up;
   endproperty
   a_quad_lead: assert property (p_quad_lead) // [RL4]
      else $error("quadrature lead did not count up");

   property p_quad_inv;
      @(posedge clk) disable iff (reset)
      (r_reg.fmt[0] == 1'b0 && r_reg.inv && !r_reg.pulse_lvl && !pulse_new
         && !r_reg.sign_lvl && sign_new)
         |=> cmd_count == $past(cmd_count) - 32'sh1 && cmd_step_neg;
   endproperty
   a_quad_inv: assert property (p_quad_inv) // [RL5]
      else $error("inverted quadrature lead did not count down");

   property p_quad_fall;
      @(posedge clk) disable iff (reset)
      (r_reg.fmt[0] == 1'b0 && r_reg.pulse_lvl && !pulse_new
         && r_reg.sign_lvl == sign_new)
         |=> cmd_count != $past(cmd_count);
   endproperty
   a_quad_fall: assert property (p_quad_fall) // [RL14]
      else $error("quadrature falling edge not counted");

   property p_separate;
      @(posedge clk) disable iff (reset)
      (r_reg.fmt == cpd_pkg::FMT_SEPARATE && !r_reg.inv && pulse_rise
         && !sign_rise) |=> cmd_step_pos && !cmd_step_neg;
   endproperty
   a_separate: assert property (p_separate) // [RL6]
      else $error("positive train pulse not counted up");

   property p_pulse_dir;
      @(posedge clk) disable iff (reset)
      (r_reg.fmt == cpd_pkg::FMT_PULSE_DIR && pulse_rise && !sign_new)
         |=> cmd_step_pos == $past(r_reg.inv) && cmd_step_neg != cmd_step_pos;
   endproperty
   a_pulse_dir: assert property (p_pulse_dir) // [RL2]
      else $error("direction line or inversion misapplied");

   property p_ppr_ratio;
      @(posedge clk) disable iff (reset)
      r_reg.ppr != cpd_pkg::PPR_OFF |-> lnk.num == cpd_pkg::ENC_RES
         && lnk.den == (cpd_pkg::GEAR_W)'(r_reg.ppr);
   endproperty
   a_ppr_ratio: assert property (p_ppr_ratio) // [RL8]
      else $error("pulses per rev ratio not applied");

   property p_gear_ratio;
      @(posedge clk) disable iff (reset)
      r_reg.ppr == cpd_pkg::PPR_OFF && gear_numerator != cpd_pkg::GEAR_ZERO
         |-> lnk.num == gear_numerator && lnk.den == gear_denominator;
   endproperty
   a_gear_ratio: assert property (p_gear_ratio) // [RL9]
      else $error("gear numerator and denominator not applied");

   property p_den_only;
      @(posedge clk) disable iff (reset)
      r_reg.ppr == cpd_pkg::PPR_OFF && gear_numerator == cpd_pkg::GEAR_ZERO
         |-> lnk.num == cpd_pkg::ENC_RES && lnk.den == gear_denominator;
   endproperty
   a_den_only: assert property (p_den_only) // [RL13]
      else $error("denominator not used as pulses per rev");

endmodule

// ### cpd_pkg.sv
// Shared constants for the command pulse decoder and its electronic gear.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package cpd_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int CNT_W = 32;
   localparam int POS_W = 48;
   localparam int GEAR_W = 31;
   localparam int PPR_W = 21;
   localparam int PEND_W = 10;

   // -----------------------------------------------------------------
   // Pulse formats
   // -----------------------------------------------------------------
   localparam logic [1:0] FMT_QUAD0 = 2'h0;
   localparam logic [1:0] FMT_SEPARATE = 2'h1;
   localparam logic [1:0] FMT_QUAD2 = 2'h2;
   localparam logic [1:0] FMT_PULSE_DIR = 2'h3;

   // -----------------------------------------------------------------
   // Reset values of the settings and other fixed constants
   // -----------------------------------------------------------------
   localparam logic PATH_DEFAULT = 1'h0;
   localparam logic INVERT_DEFAULT = 1'h0;
   localparam logic [1:0] FMT_DEFAULT = FMT_SEPARATE;
   localparam logic [PPR_W-1:0] PPR_DEFAULT = 21'h02710;
   localparam logic [PPR_W-1:0] PPR_OFF = 21'h0;
   localparam logic [GEAR_W-1:0] GEAR_ZERO = 31'h0;
   localparam logic [GEAR_W-1:0] GEAR_ONE = 31'h1;
   // Encoder counts per motor revolution; plain default, set per motor
   localparam logic [GEAR_W-1:0] ENC_RES = 31'h100000;

   // -----------------------------------------------------------------
   // Gear divider sequencing
   // -----------------------------------------------------------------
   localparam logic [5:0] DIV_LAST = 6'h2f;
   localparam logic [5:0] DIV_FIRST = 6'h0;

   typedef enum logic [1:0]
   {
      GEAR_IDLE = 2'b00,
      GEAR_DIV = 2'b01,
      GEAR_FIX = 2'b10
   } gear_state_t;

endpackage

// ### gear_link_if.sv
// Link between the pulse decoder and the gear scaler.
// Assumes both ends run on the same clock; no timing lives here.
`timescale 1ns/1ps
interface gear_link_if;
   logic ev_valid;
   logic ev_up;
   logic [cpd_pkg::GEAR_W-1:0] num;
   logic [cpd_pkg::GEAR_W-1:0] den;
   logic q_valid;
   logic signed [cpd_pkg::POS_W-1:0] q;

   modport source
   (
      output ev_valid, ev_up, num, den,
      input q_valid, q
   );
   modport gear
   (
      input ev_valid, ev_up, num, den,
      output q_valid, q
   );
endinterface

// ### gear_scaler.sv
// Electronic gear: scales signed count events by num/den, exactly.
// Assumes events arrive one per cycle at most, far slower than a batch.
`timescale 1ns/1ps
module gear_scaler
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Decoder side
   gear_link_if.gear lnk
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      cpd_pkg::gear_state_t st;
      logic signed [cpd_pkg::PEND_W-1:0] pend;
      logic [cpd_pkg::GEAR_W-1:0] rem;
      logic [cpd_pkg::GEAR_W-1:0] den;
      logic [cpd_pkg::POS_W-1:0] dividend;
      logic [cpd_pkg::GEAR_W:0] part;
      logic [cpd_pkg::POS_W-1:0] quot;
      logic neg;
      logic [5:0] steps;
      logic q_valid;
      logic signed [cpd_pkg::POS_W-1:0] q;
   } gear_reg_t;

   localparam gear_reg_t GEAR_RESET = '0;

   gear_reg_t r_reg;
   gear_reg_t r_next;
   logic signed [cpd_pkg::PEND_W:0] pend_sum;
   logic signed [cpd_pkg::POS_W-1:0] total;
   logic [cpd_pkg::GEAR_W:0] shifted;
   logic signed [cpd_pkg::POS_W-1:0] total_hold_reg;

   // -----------------------------------------------------------------
   // Batch, divide, fix sign
   // -----------------------------------------------------------------
   // Events keep piling into pend while a divide runs, so none are lost
   always_comb
   begin
      r_next = r_reg;
      r_next.q_valid = 1'b0;
      pend_sum = (cpd_pkg::PEND_W+1)'(r_reg.pend);
      if (lnk.ev_valid)
         pend_sum = lnk.ev_up ? pend_sum + 11'sh1 : pend_sum - 11'sh1;
      // [RL10] numerator multiplies
      total = signed'({17'h0, r_reg.rem})
         + (cpd_pkg::POS_W)'(pend_sum) * signed'({17'h0, lnk.num});
      shifted = {r_reg.part[cpd_pkg::GEAR_W-1:0],
         r_reg.dividend[cpd_pkg::POS_W-1]};
      r_next.pend = (cpd_pkg::PEND_W)'(pend_sum);
      case (r_reg.st)
         cpd_pkg::GEAR_IDLE:
         begin
            if (pend_sum != 11'sh0)
            begin
               r_next.pend = '0;
               // A zero divisor is never legal; fall back to one
               r_next.den = (lnk.den == cpd_pkg::GEAR_ZERO) ?
                  cpd_pkg::GEAR_ONE : lnk.den;
               r_next.neg = total[cpd_pkg::POS_W-1];
               r_next.dividend = total[cpd_pkg::POS_W-1] ?
                  unsigned'(-total) : unsigned'(total);
               r_next.part = '0;
               r_next.quot = '0;
               r_next.steps = cpd_pkg::DIV_FIRST;
               r_next.st = cpd_pkg::GEAR_DIV;
            end
         end
         cpd_pkg::GEAR_DIV:
         begin
            // [RL11] restoring divide by denominator
            r_next.dividend = {r_reg.dividend[cpd_pkg::POS_W-2:0], 1'b0};
            if (shifted >= {1'b0, r_reg.den})
            begin
               r_next.part = shifted - {1'b0, r_reg.den};
               r_next.quot = {r_reg.quot[cpd_pkg::POS_W-2:0], 1'b1};
            end
            else
            begin
               r_next.part = shifted;
               r_next.quot = {r_reg.quot[cpd_pkg::POS_W-2:0], 1'b0};
            end
            r_next.steps = r_reg.steps + 6'h1;
            if (r_reg.steps == cpd_pkg::DIV_LAST)
               r_next.st = cpd_pkg::GEAR_FIX;
         end
         cpd_pkg::GEAR_FIX:
         begin
            // [RL15] floor division keeps remainder
            if (!r_reg.neg)
            begin
               r_next.q = signed'(r_reg.quot);
               r_next.rem = r_reg.part[cpd_pkg::GEAR_W-1:0];
            end
            else if (r_reg.part != '0)
            begin
               r_next.q = -signed'(r_reg.quot + 48'h1);
               r_next.rem = r_reg.den - r_reg.part[cpd_pkg::GEAR_W-1:0];
            end
            else
            begin
               r_next.q = -signed'(r_reg.quot);
               r_next.rem = '0;
            end
            r_next.q_valid = 1'b1;
            r_next.st = cpd_pkg::GEAR_IDLE;
         end
         default:
            r_next.st = cpd_pkg::GEAR_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         r_reg <= GEAR_RESET;
      else
         r_reg <= r_next;
   end

   assign lnk.q_valid = r_reg.q_valid;
   assign lnk.q = r_reg.q;

   // Helper for checking: dividend of the batch in flight
   always_ff @(posedge clk)
   begin
      if (reset)
         total_hold_reg <= '0;
      else if (r_reg.st == cpd_pkg::GEAR_IDLE && pend_sum != 11'sh0)
         total_hold_reg <= total;
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_gear_exact;
      @(posedge clk) disable iff (reset)
      r_reg.q_valid |-> (r_reg.q * signed'({17'h0, r_reg.den})
         + signed'({17'h0, r_reg.rem}) == total_hold_reg);
   endproperty
   a_gear_exact: assert property (p_gear_exact) // [RL15]
      else $error("gear quotient and remainder do not rebuild dividend");

   property p_gear_rem_range;
      @(posedge clk) disable iff (reset)
      r_reg.q_valid |-> r_reg.rem < r_reg.den;
   endproperty
   a_gear_rem_range: assert property (p_gear_rem_range) // [RL11]
      else $error("gear remainder not below denominator");

   property p_gear_latency;
      @(posedge clk) disable iff (reset)
      $rose(r_reg.st == cpd_pkg::GEAR_DIV)
         |-> ##48 (r_reg.st == cpd_pkg::GEAR_FIX) ##1 r_reg.q_valid;
   endproperty
   a_gear_latency: assert property (p_gear_latency) // [RL10]
      else $error("gear batch did not finish in 50 cycles");

endmodule

// ### host_pulse_model.sv
// Host controller model: turns requested line levels into the
// differential leg pairs of both command input paths.
// Assumes the bench paces each level change within the host rate limits.
`timescale 1ns/1ps
module host_pulse_model
(
   // Requested line levels
   input wire logic opto_pulse_lvl,
   input wire logic opto_sign_lvl,
   input wire logic diff_pulse_lvl,
   input wire logic diff_sign_lvl,
   // Optocoupler pairs
   output logic opto_pulse_pos,
   output logic opto_pulse_neg,
   output logic opto_sign_pos,
   output logic opto_sign_neg,
   // Dedicated differential pairs
   output logic diff_pulse_pos,
   output logic diff_pulse_neg,
   output logic diff_sign_pos,
   output logic diff_sign_neg
);
   // Legs always complementary; equal legs would freeze the line level
   assign opto_pulse_pos = opto_pulse_lvl;
   assign opto_pulse_neg = ~opto_pulse_lvl;
   assign opto_sign_pos = opto_sign_lvl;
   assign opto_sign_neg = ~opto_sign_lvl;
   assign diff_pulse_pos = diff_pulse_lvl;
   assign diff_pulse_neg = ~diff_pulse_lvl;
   assign diff_sign_pos = diff_sign_lvl;
   assign diff_sign_neg = ~diff_sign_lvl;
endmodule

// ### test_command_pulse_decoder_gear.sv
// Self-checking bench for the command pulse decoder and gear.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps
module test_command_pulse_decoder_gear;
   // -----------------------------------------------------------------
   // Stimulus and observation
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic power_up = 1'b0;
   logic input_path_select = 1'b0;
   logic direction_invert = 1'b0;
   logic [1:0] pulse_format_select = cpd_pkg::FMT_SEPARATE;
   logic [cpd_pkg::PPR_W-1:0] pulses_per_rev = cpd_pkg::PPR_DEFAULT;
   logic [cpd_pkg::GEAR_W-1:0] gear_numerator = cpd_pkg::GEAR_ZERO;
   logic [cpd_pkg::GEAR_W-1:0] gear_denominator = 31'h00002710;
   logic opto_p = 1'b0;
   logic opto_s = 1'b0;
   logic diff_p = 1'b0;
   logic diff_s = 1'b0;
   wire logic op_pp, op_pn, op_sp, op_sn, df_pp, df_pn, df_sp, df_sn;
   logic cmd_step_pos;
   logic cmd_step_neg;
   logic signed [cpd_pkg::CNT_W-1:0] cmd_count;
   logic signed [cpd_pkg::POS_W-1:0] position_cmd;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_up = 0;
   int n_dn = 0;
   longint exp_cnt = 0, exp_pos = 0, exp_up = 0, exp_dn = 0;
   longint pend = 0, rem = 0, g_num = 1048576, g_den = 10000;

   host_pulse_model host_pulse_model_inst
   (
      .opto_pulse_lvl(opto_p), .opto_sign_lvl(opto_s),
      .diff_pulse_lvl(diff_p), .diff_sign_lvl(diff_s),
      .opto_pulse_pos(op_pp), .opto_pulse_neg(op_pn),
      .opto_sign_pos(op_sp), .opto_sign_neg(op_sn),
      .diff_pulse_pos(df_pp), .diff_pulse_neg(df_pn),
      .diff_sign_pos(df_sp), .diff_sign_neg(df_sn)
   );

   command_pulse_decoder_gear command_pulse_decoder_gear_inst
   (
      .clk(clk), .reset(reset),
      .opto_pulse_pos(op_pp), .opto_pulse_neg(op_pn),
      .opto_sign_pos(op_sp), .opto_sign_neg(op_sn),
      .diff_pulse_pos(df_pp), .diff_pulse_neg(df_pn),
      .diff_sign_pos(df_sp), .diff_sign_neg(df_sn),
      .power_up(power_up), .input_path_select(input_path_select),
      .direction_invert(direction_invert),
      .pulse_format_select(pulse_format_select),
      .pulses_per_rev(pulses_per_rev), .gear_numerator(gear_numerator),
      .gear_denominator(gear_denominator),
      .cmd_step_pos(cmd_step_pos), .cmd_step_neg(cmd_step_neg),
      .cmd_count(cmd_count), .position_cmd(position_cmd)
   );

   // -----------------------------------------------------------------
   // Clock, step tally and hang guard
   // -----------------------------------------------------------------
   always #10 clk = ~clk;

   // Whole run is near 5300 cycles; the ceiling leaves wide margin
   always @(posedge clk)
   begin
      cyc++;
      if (cmd_step_pos === 1'b1)
         n_up++;
      if (cmd_step_neg === 1'b1)
         n_dn++;
      if (cyc == 20000)
      begin
         errors++;
         stop_test();
      end
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic stop_test();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Let gear batches finish, then fold pending counts exactly
   task automatic check_all();
      longint tot, q;
      repeat (150) @(posedge clk);
      tot = rem + pend * g_num;
      q = tot / g_den;
      if (tot % g_den < 0)
         q = q - 1;
      rem = tot - q * g_den;
      exp_pos += q;
      pend = 0;
      #1;
      cmp(cmd_count, exp_cnt);
      cmp(position_cmd, exp_pos);
      cmp(n_up, exp_up);
      cmp(n_dn, exp_dn);
   endtask

   task automatic ev(input longint n);
      exp_cnt += n;
      pend += n;
      if (n > 0)
         exp_up += n;
      else
         exp_dn -= n;
   endtask

   // 1 us per level keeps every path in its rate
   task automatic lv(input logic path, input logic p, input logic s);
      @(posedge clk);
      #1;
      if (path)
         {diff_p, diff_s} = {p, s};
      else
         {opto_p, opto_s} = {p, s};
      repeat (49) @(posedge clk);
   endtask

   task automatic sep(input logic path, input logic neg, input int n);
      repeat (n)
      begin
         lv(path, ~neg, neg);
         lv(path, 1'b0, 1'b0);
      end
   endtask

   // Sign leads pulse by a quarter cycle when lead is set
   task automatic quad(input logic path, input logic lead);
      lv(path, ~lead, lead);
      lv(path, 1'b1, 1'b1);
      lv(path, lead, ~lead);
      lv(path, 1'b0, 1'b0);
   endtask

   task automatic cfg(input logic path, input logic inv,
                      input logic [1:0] fmt, input logic [20:0] ppr);
      @(posedge clk);
      #1;
      {input_path_select, direction_invert} = {path, inv};
      pulse_format_select = fmt;
      pulses_per_rev = ppr;
      power_up = 1'b1;
      @(posedge clk);
      #1;
      power_up = 1'b0;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_defaults();
      check_all();
      sep(1'b0, 1'b0, 2);
      ev(2);
      sep(1'b0, 1'b1, 1);
      ev(-1);
      check_all();
   endtask

   // Port changes without power-up must not take effect
   task automatic t_latched();
      @(posedge clk);
      #1;
      {input_path_select, direction_invert} = 2'h3;
      pulse_format_select = cpd_pkg::FMT_PULSE_DIR;
      pulses_per_rev = cpd_pkg::PPR_OFF;
      sep(1'b0, 1'b0, 1);
      ev(1);
      sep(1'b1, 1'b0, 1);
      check_all();
   endtask

   task automatic t_quad();
      cfg(1'b1, 1'b0, cpd_pkg::FMT_QUAD0, cpd_pkg::PPR_DEFAULT);
      quad(1'b1, 1'b1);
      quad(1'b1, 1'b1);
      ev(8);
      quad(1'b1, 1'b0);
      ev(-4);
      quad(1'b0, 1'b1);
      check_all();
      cfg(1'b1, 1'b1, cpd_pkg::FMT_QUAD2, cpd_pkg::PPR_DEFAULT);
      quad(1'b1, 1'b1);
      ev(-4);
      quad(1'b1, 1'b0);
      ev(4);
      check_all();
   endtask

   task automatic t_dir();
      for (int i = 0; i < 2; i++)
      begin
         cfg(1'b0, i[0], cpd_pkg::FMT_PULSE_DIR, cpd_pkg::PPR_DEFAULT);
         lv(1'b0, 1'b0, 1'b1);
         // Sign stays high while the pulse rises: counts up without inversion, down with it
         lv(1'b0, 1'b1, 1'b1);
         ev(i ? -1 : 1);
         lv(1'b0, 1'b0, 1'b0);
         sep(1'b0, 1'b0, 1);
         ev(i ? 1 : -1);
         check_all();
      end
      cfg(1'b0, 1'b1, cpd_pkg::FMT_SEPARATE, cpd_pkg::PPR_DEFAULT);
      sep(1'b0, 1'b0, 1);
      ev(-1);
      check_all();
   endtask

   // Odd ratios leave remainders that must carry between batches
   task automatic t_gear();
      gear_denominator = 31'h00001388;
      cfg(1'b0, 1'b0, cpd_pkg::FMT_SEPARATE, cpd_pkg::PPR_OFF);
      {g_num, g_den} = {64'd1048576, 64'd5000};
      sep(1'b0, 1'b0, 3);
      ev(3);
      check_all();
      gear_numerator = 31'h00000003;
      gear_denominator = 31'h00000007;
      {g_num, g_den} = {64'd3, 64'd7};
      sep(1'b0, 1'b0, 2);
      ev(2);
      check_all();
      sep(1'b0, 1'b0, 3);
      ev(3);
      check_all();
      sep(1'b0, 1'b1, 4);
      ev(-4);
      check_all();
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      #1;
      reset = 1'b0;
      t_defaults();
      t_latched();
      t_quad();
      t_dir();
      t_gear();
      stop_test();
   end
endmodule
